//--- design/encoder_param_command_diag.sv
// Purpose: Parameter checks, edge commands and diagnostic attributes
// Assumes: One request per cycle; answer one cycle later, get-all words two to four cycles later
// Notes:   Scaling arithmetic lives outside; only the limits are checked here
`timescale 1ns/10ps
module encoder_param_command_diag
    import param_diag_pkg::*;
#(
    parameter logic [31:0] UNITS_MAX      = 32'h0004_0000,
    parameter logic [31:0] RANGE_MAX      = 32'h4000_0000,
    parameter logic [31:0] OFFSET_LIMIT   = 32'h4000_0000,
    parameter logic [31:0] DEF_UNITS      = 32'h0000_2000,
    parameter logic [31:0] DEF_RANGE      = 32'h0800_0000,
    parameter logic [31:0] DEF_PRESET     = 32'h0000_0000
) (
    input  wire logic                           i_sys_clk,
    input  wire logic                           i_reset_n,
    input  wire param_diag_pkg::attr_req_s      i_req,
    input  wire param_diag_pkg::device_status_s i_status,
    output logic                                o_ack,
    output logic                                o_error,
    output logic [31:0]                         o_rdata,
    output logic [31:0]                         o_position,
    output logic                                o_save_busy
);
    import param_diag_pkg::*;

    // ==========================================================
    // Working parameters (volatile)
    logic [31:0] units_per_span;
    logic [31:0] total_range;
    logic [31:0] preset_value;
    logic [31:0] offset_value;
    logic [3:0]  wrong_params;
    logic [7:0]  cmd_prev;
    logic        preset_pending;
    logic [2:0]  save_idx;
    logic        restore_load;
    logic [2:0]  restore_idx;

    function automatic logic out_of_range(input logic [31:0] v, input logic [31:0] lim);
        out_of_range = (v == RESET_ZERO) || (v > lim);
    endfunction : out_of_range

    function automatic logic [31:0] calc_offset(input logic [31:0] raw, input logic [31:0] pre);
        calc_offset = raw - pre;
    endfunction : calc_offset

    // ==========================================================
    // Request decode
    wire        set_req      = i_req.valid && !i_req.is_class && i_req.service == SVC_SET_SINGLE;
    wire        get_req      = i_req.valid && (i_req.service == SVC_GET_SINGLE);
    wire        get_all_req  = i_req.valid && i_req.is_class && i_req.service == SVC_GET_ALL;
    wire        wr_units     = set_req && i_req.attr == ATTR_UNITS_PER_SPAN;
    wire        wr_range     = set_req && i_req.attr == ATTR_TOTAL_RANGE;
    wire        wr_preset    = set_req && i_req.attr == ATTR_PRESET_VALUE;
    wire        wr_cmd       = set_req && i_req.attr == ATTR_COMMAND;
    wire [7:0]  cmd_new      = i_req.data[7:0] & CMD_USED_MASK;
    wire [7:0]  cmd_rise     = wr_cmd ? (cmd_new & ~cmd_prev) : 8'h00;
    wire        act_preset   = cmd_rise[CMD_PRESET_BIT] || wr_preset;
    wire        do_save      = cmd_rise[CMD_SAVE_BIT];
    wire        do_restore   = cmd_rise[CMD_RESTORE_BIT];
    wire [31:0] act_preset_v = wr_preset ? i_req.data : preset_value;
    wire [31:0] next_offset  = calc_offset(i_status.raw_position, act_preset_v);
    wire        offset_bad   = out_of_range(next_offset + 32'h0000_0001, OFFSET_LIMIT);
    wire        warn_active  = |wrong_params;
    wire [15:0] warnings     = {2'b00, warn_active, 13'h0000};
    wire [7:0]  summary      = {6'h00, warn_active, i_status.alarm_active};
    wire [31:0] prod_serial  = {i_status.serial_year, i_status.serial_week,
                                i_status.serial_count};

    // ==========================================================
    // Non-volatile copy: save walks four words, restore does not read them back
    logic        nv_we;
    logic [1:0]  nv_waddr;
    logic [31:0] nv_wdata;
    logic [31:0] nv_rdata;
    wire  [1:0]  nv_raddr = 2'(restore_idx);

    assign nv_we    = save_idx != 3'd0;
    assign nv_waddr = 2'(save_idx - 3'd1);
    always_comb begin
        case (nv_waddr)
            2'd0:    nv_wdata = units_per_span;
            2'd1:    nv_wdata = total_range;
            2'd2:    nv_wdata = preset_value;
            default: nv_wdata = offset_value;
        endcase
    end

    nv_param_store #(.WIDTH(32), .DEPTH(4)) u_store (
        .i_sys_clk (i_sys_clk),
        .i_we      (nv_we),
        .i_waddr   (nv_waddr),
        .i_wdata   (nv_wdata),
        .i_raddr   (nv_raddr),
        .o_rdata   (nv_rdata)
    );

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            save_idx <= 3'd0;
        end else if (do_save && save_idx == 3'd0) begin
            save_idx <= 3'd1;
        end else if (save_idx == 3'd4) begin
            save_idx <= 3'd0;
        end else if (save_idx != 3'd0) begin
            save_idx <= save_idx + 3'd1;
        end
    end
    assign o_save_busy = save_idx != 3'd0;

    // Restore only reloads factory defaults; the stored copy is kept but nothing reads it back
    assign restore_load = 1'b0;
    assign restore_idx  = 3'd0;

    // ==========================================================
    // Parameters, flags and commands
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            units_per_span <= DEF_UNITS;
            total_range    <= DEF_RANGE;
            preset_value   <= DEF_PRESET;
            offset_value   <= RESET_ZERO;
            wrong_params   <= 4'h0;
            cmd_prev       <= 8'h00;
        end else if (do_restore) begin
            units_per_span <= DEF_UNITS;
            total_range    <= DEF_RANGE;
            preset_value   <= DEF_PRESET;
            offset_value   <= RESET_ZERO;
            wrong_params   <= 4'h0;
            cmd_prev       <= cmd_new;
        end else begin
            if (wr_cmd) begin
                cmd_prev <= cmd_new;
            end
            if (wr_units) begin
                units_per_span               <= i_req.data;
                wrong_params[WP_UNITS_BIT]   <= out_of_range(i_req.data, UNITS_MAX);
            end
            if (wr_range) begin
                total_range                  <= i_req.data;
                wrong_params[WP_RANGE_BIT]   <= out_of_range(i_req.data, RANGE_MAX);
            end
            if (wr_preset) begin
                preset_value                 <= i_req.data;
                wrong_params[WP_PRESET_BIT]  <= i_req.data >= total_range;
            end
            if (act_preset) begin
                offset_value                 <= next_offset;
                wrong_params[WP_OFFSET_BIT]  <= offset_bad;
            end
        end
    end

    // Reported position follows the offset so the preset spot reads the preset
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_position <= RESET_ZERO;
        end else begin
            o_position <= i_status.raw_position - offset_value;
        end
    end

    // ==========================================================
    // Read answers
    logic [31:0] read_mux;
    logic        read_ok;
    always_comb begin
        read_ok  = 1'b1;
        read_mux = RESET_ZERO;
        if (i_req.is_class) begin
            case (i_req.attr)
                CLASS_REVISION:     read_mux = {16'h0000, CLASS_REVISION_VAL};
                CLASS_MAX_INSTANCE: read_mux = {16'h0000, CLASS_MAX_INST_VAL};
                CLASS_INST_COUNT:   read_mux = {16'h0000, CLASS_INST_CNT_VAL};
                default:            read_ok  = 1'b0;
            endcase
        end else begin
            case (i_req.attr)
                ATTR_UNITS_PER_SPAN: read_mux = units_per_span;
                ATTR_TOTAL_RANGE:    read_mux = total_range;
                ATTR_PRESET_VALUE:   read_mux = preset_value;
                ATTR_WARNINGS:       read_mux = {16'h0000, warnings};
                ATTR_WARNING_FLAG:   read_mux = {31'h0000_0000, warn_active};
                ATTR_OFFSET_VALUE:   read_mux = offset_value;
                ATTR_WRONG_PARAMS:   read_mux = {28'h000_0000, wrong_params};
                ATTR_SUMMARY:        read_mux = {24'h00_0000, summary};
                ATTR_PROD_SERIAL:    read_mux = prod_serial;
                ATTR_NET_SERIAL:     read_mux = i_status.net_serial;
                default:             read_ok  = 1'b0;
            endcase
        end
    end

    // Get-all returns the three class words in order, one per cycle
    logic [1:0] all_idx;
    wire        all_busy = all_idx != 2'd0;
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            all_idx <= 2'd0;
        end else if (get_all_req && !all_busy) begin
            all_idx <= 2'd1;
        end else if (all_idx == 2'(GET_ALL_WORDS)) begin
            all_idx <= 2'd0;
        end else if (all_busy) begin
            all_idx <= all_idx + 2'd1;
        end
    end

    wire [31:0] all_word = (all_idx == 2'd1) ? {16'h0000, CLASS_REVISION_VAL} :
                           (all_idx == 2'd2) ? {16'h0000, CLASS_MAX_INST_VAL} :
                                               {16'h0000, CLASS_INST_CNT_VAL};
    wire set_ok  = set_req && (wr_units || wr_range || wr_preset || wr_cmd);
    wire bad_req = i_req.valid && !all_busy && !get_all_req && !set_ok
                   && !(get_req && read_ok);

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_ack   <= 1'b0;
            o_error <= 1'b0;
            o_rdata <= RESET_ZERO;
        end else if (all_busy) begin
            o_ack   <= 1'b1;
            o_error <= 1'b0;
            o_rdata <= all_word;
        end else begin
            o_ack   <= i_req.valid && !get_all_req;
            o_error <= bad_req;
            o_rdata <= (get_req && read_ok) ? read_mux : RESET_ZERO;
        end
    end

    // ==========================================================
    // Checks
    a_preset_edge_once: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (wr_cmd && cmd_new[CMD_PRESET_BIT] && cmd_prev[CMD_PRESET_BIT] && !wr_preset)
        |-> !act_preset) else $error("preset repeated on held bit");
    a_offset_capture: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (act_preset && !do_restore) |=> offset_value == $past(next_offset))
        else $error("offset not captured");
    a_preset_write_act: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        wr_preset |-> act_preset) else $error("preset write did not activate");
    a_warn_bit_13: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        warnings[WARN_PARAM_BIT] == (wrong_params != 4'h0)) else $error("warning bit wrong");
    a_units_flag: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (wr_units && !do_restore) |=> wrong_params[WP_UNITS_BIT]
            == out_of_range($past(i_req.data), UNITS_MAX)) else $error("units flag wrong");
    a_restore_default: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        do_restore |=> (units_per_span == DEF_UNITS && wrong_params == 4'h0))
        else $error("restore incomplete");
    a_save_walk: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (do_save && !o_save_busy) |=> nv_we [*4] ##1 !nv_we) else $error("save walk wrong");
    a_summary_bits: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        summary == {6'h00, warn_active, i_status.alarm_active} && summary[7:2] == 6'h00)
        else $error("summary wrong");
    a_class_revision: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (get_req && i_req.is_class && i_req.attr == CLASS_REVISION && !all_busy)
        |=> o_rdata == 32'h0000_0004) else $error("revision wrong");

    // ==========================================================
    // Further checks on flags, answers and the get-all burst
    // Preset limit is judged against the range that stood when the preset came in
    a_preset_flag: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (wr_preset && !do_restore) |=> wrong_params[WP_PRESET_BIT]
            == ($past(i_req.data) >= $past(total_range))) else $error("preset flag wrong");
    a_range_flag: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (wr_range && !do_restore) |=> wrong_params[WP_RANGE_BIT]
            == out_of_range($past(i_req.data), RANGE_MAX)) else $error("range flag wrong");
    a_error_has_ack: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        o_error |-> o_ack) else $error("error without ack");
    a_ack_next_cycle: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_req.valid && !all_busy && !get_all_req) |=> o_ack) else $error("answer missing");
    a_position_track: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        1'b1 |=> o_position == $past(i_status.raw_position) - $past(offset_value))
        else $error("position not relative to offset");
    a_cmd_masked: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (cmd_prev & ~CMD_USED_MASK) == 8'h00) else $error("unused command bit kept");

    // The burst is three answer words in fixed order, one per cycle
    sequence s_word_revision;
        o_ack && o_rdata == {16'h0000, CLASS_REVISION_VAL};
    endsequence
    sequence s_word_max_inst;
        o_ack && o_rdata == {16'h0000, CLASS_MAX_INST_VAL};
    endsequence
    sequence s_word_inst_cnt;
        o_ack && o_rdata == {16'h0000, CLASS_INST_CNT_VAL};
    endsequence
    a_get_all_burst: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (get_all_req && !all_busy) |=> !o_ack ##1 s_word_revision ##1 s_word_max_inst
            ##1 s_word_inst_cnt) else $error("get-all burst wrong");
endmodule : encoder_param_command_diag

//--- design/param_diag_pkg.sv
// Purpose: Constants and carriers for the encoder parameter/command/diagnostic bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Attribute offsets are the printed attribute numbers
//
// Overview of operation
// - Invalid parameter write raises parameters warning and sets matching list bit.
// - List bits: 0 units-per-turn, 1 total range, 2 preset, 3 offset.
// - Preset giving out-of-tolerance offset sets offset-exceeded flag.
// - Flags and warning clear when parameter rewritten within tolerance.
// - Preset activation once per rising edge of command bit 0.
// - On activation current location reports preset, others relative to it.
// - On activation current raw position minus preset is captured into volatile offset.
// - Writing preset value attribute triggers preset activation by itself.
// - Unsaved parameters and offset live only in volatile storage.
// - Rising edge of command bit 6 copies parameters to non-volatile memory.
// - Rising edge of command bit 7 restores factory defaults.
// - Status byte: bit 0 alarms active, bit 1 warnings active.
// - Serial word: year 31..24, week 23..16, ascending count in low half.
// - Interface object class supports get-all and get-single services.
// - Interface object class revision reads four.
// - Interface object class max instance and instance count read one.
// - Parameters warning is warnings bit 13; warning flag set when any active.
package param_diag_pkg;

    // ==========================================================
    // Attribute addresses
    localparam logic [7:0]  ATTR_UNITS_PER_SPAN = 8'h10;
    localparam logic [7:0]  ATTR_TOTAL_RANGE    = 8'h11;
    localparam logic [7:0]  ATTR_PRESET_VALUE   = 8'h13;
    localparam logic [7:0]  ATTR_WARNINGS       = 8'h2F;
    localparam logic [7:0]  ATTR_WARNING_FLAG   = 8'h31;
    localparam logic [7:0]  ATTR_OFFSET_VALUE   = 8'h33;
    localparam logic [7:0]  ATTR_WRONG_PARAMS   = 8'h67;
    localparam logic [7:0]  ATTR_COMMAND        = 8'h68;
    localparam logic [7:0]  ATTR_SUMMARY        = 8'h69;
    localparam logic [7:0]  ATTR_PROD_SERIAL    = 8'h6A;
    localparam logic [7:0]  ATTR_NET_SERIAL     = 8'h6C;
    localparam logic [7:0]  CLASS_REVISION      = 8'h01;
    localparam logic [7:0]  CLASS_MAX_INSTANCE  = 8'h02;
    localparam logic [7:0]  CLASS_INST_COUNT    = 8'h03;

    // ==========================================================
    // Services
    localparam logic [7:0]  SVC_GET_ALL         = 8'h01;
    localparam logic [7:0]  SVC_GET_SINGLE      = 8'h0E;
    localparam logic [7:0]  SVC_SET_SINGLE      = 8'h10;

    // ==========================================================
    // Field positions
    localparam int          WP_UNITS_BIT        = 0;
    localparam int          WP_RANGE_BIT        = 1;
    localparam int          WP_PRESET_BIT       = 2;
    localparam int          WP_OFFSET_BIT       = 3;
    localparam int          CMD_PRESET_BIT      = 0;
    localparam int          CMD_SAVE_BIT        = 6;
    localparam int          CMD_RESTORE_BIT     = 7;
    localparam int          SUM_ALARM_BIT       = 0;
    localparam int          SUM_WARN_BIT        = 1;
    localparam int          WARN_PARAM_BIT      = 13;
    localparam int          SER_YEAR_LSB        = 24;
    localparam int          SER_WEEK_LSB        = 16;

    // ==========================================================
    // Fixed values and reset values
    localparam logic [15:0] CLASS_REVISION_VAL  = 16'h0004;
    localparam logic [15:0] CLASS_MAX_INST_VAL  = 16'h0001;
    localparam logic [15:0] CLASS_INST_CNT_VAL  = 16'h0001;
    localparam logic [7:0]  CMD_USED_MASK       = 8'hC1;
    localparam logic [31:0] RESET_ZERO          = 32'h0000_0000;
    localparam int          GET_ALL_WORDS       = 3;

    // Status carrier from the device side
    typedef struct packed {
        logic        alarm_active;
        logic [31:0] raw_position;
        logic [7:0]  serial_year;
        logic [7:0]  serial_week;
        logic [15:0] serial_count;
        logic [31:0] net_serial;
    } device_status_s;

    // Attribute request carrier
    typedef struct packed {
        logic        valid;
        logic        is_class;
        logic [7:0]  service;
        logic [7:0]  attr;
        logic [31:0] data;
    } attr_req_s;

endpackage : param_diag_pkg

//--- design/nv_param_store.sv
// Purpose: Small non-volatile parameter store, registered read
// Assumes: Contents survive reset; power-down modelled outside
// Notes:   Holds units per span, total range, preset, offset
`timescale 1ns/10ps
module nv_param_store #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_we,
    input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
    input  wire logic [WIDTH-1:0]         i_wdata,
    input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
    output logic      [WIDTH-1:0]         o_rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge i_sys_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule : nv_param_store

//--- sim/encoder_front_model.sv
// Purpose: Encoder front end feeding raw position, alarm and serial fields
// Assumes: Bench sets raw position and alarm; fields registered on the clock
// Notes:   Serial and network values are arbitrary test values
`timescale 1ns/10ps
module encoder_front_model
    import param_diag_pkg::*;
#(
    parameter logic [7:0]  YEAR    = 8'h21,
    parameter logic [7:0]  WEEK    = 8'h07,
    parameter logic [15:0] COUNT   = 16'h0123,
    parameter logic [31:0] NET_SER = 32'hA5C3_0F1E
) (
    input  wire logic                      i_sys_clk,
    input  wire logic [31:0]               i_raw,
    input  wire logic                      i_alarm,
    output param_diag_pkg::device_status_s o_status
);
    // =======================================================
    // Registered so the bank sees a clean level one edge later
    always_ff @(posedge i_sys_clk) begin
        o_status <= '{alarm_active: i_alarm, raw_position: i_raw, serial_year: YEAR,
                      serial_week: WEEK, serial_count: COUNT, net_serial: NET_SER};
    end
endmodule : encoder_front_model

//--- sim/tb_top.sv
// Purpose: Self-checking bench for the parameter, command and diagnostic bank
// Assumes: One request at a time, answer awaited before the next
// Notes:   Expected values come from the package constants and the defaults
`timescale 1ns/10ps
module tb_top;
    import param_diag_pkg::*;
    logic           clk;
    logic           rst_n;
    attr_req_s      req;
    device_status_s status;
    logic [31:0]    raw;
    logic           alarm;
    logic           ack;
    logic           err;
    logic [31:0]    rdata;
    logic [31:0]    pos;
    logic           busy;
    logic [31:0]    rd;
    logic           er;
    int             failures;
    int             checked;
    int             n;

    encoder_front_model front (.i_sys_clk(clk), .i_raw(raw), .i_alarm(alarm), .o_status(status));
    encoder_param_command_diag dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_req(req),
        .i_status(status), .o_ack(ack), .o_error(err), .o_rdata(rdata), .o_position(pos),
        .o_save_busy(busy));

    always #5 clk = ~clk;

    // =======================================================
    // Access tasks
    task automatic settle;
        @(posedge clk);
        #1;
    endtask : settle

    task automatic xfer(input logic cls, input logic [7:0] svc, input logic [7:0] a,
                        input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        req <= '{valid: 1'b1, is_class: cls, service: svc, attr: a, data: d};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        // Bounded wait so a missing answer cannot hang the run
        while (ack !== 1'b1 && k < 8) begin
            k++;
            settle();
        end
        if (k >= 8) failures++;
        rd = rdata;
        er = err;
    endtask : xfer

    task automatic get(input logic [7:0] a);
        xfer(1'b0, SVC_GET_SINGLE, a, 32'h0);
    endtask : get

    task automatic set(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b0, SVC_SET_SINGLE, a, d);
    endtask : set

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test;
        if (failures == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test

    // =======================================================
    // Watchdog
    initial begin
        #200000;
        failures++;
        finish_test();
    end

    // =======================================================
    // Tests
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        req = '0;
        raw = 32'd100;
        alarm = 1'b0;
        failures = 0;
        checked = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        get(ATTR_WRONG_PARAMS);
        chk(rd, 32'h0);
        get(ATTR_SUMMARY);
        chk(rd, 32'h0);
        set(ATTR_UNITS_PER_SPAN, 32'h0);
        get(ATTR_WRONG_PARAMS);
        chk(rd, 32'h1);
        get(ATTR_WARNINGS);
        chk(rd, 32'h0000_2000);
        get(ATTR_WARNING_FLAG);
        chk(rd, 32'h1);
        get(ATTR_SUMMARY);
        chk(rd, 32'h2);
        alarm = 1'b1;
        get(ATTR_SUMMARY);
        chk(rd, 32'h3);
        set(ATTR_TOTAL_RANGE, 32'h0);
        get(ATTR_WRONG_PARAMS);
        chk(rd, 32'h3);
        set(ATTR_UNITS_PER_SPAN, 32'h0000_2000);
        get(ATTR_WRONG_PARAMS);
        chk(rd, 32'h2);
        set(ATTR_TOTAL_RANGE, 32'h0800_0000);
        get(ATTR_WARNINGS);
        chk(rd, 32'h0);
        get(ATTR_SUMMARY);
        chk(rd, 32'h1);
        alarm = 1'b0;
        // Preset above raw would give a negative offset
        set(ATTR_PRESET_VALUE, 32'd200);
        get(ATTR_WRONG_PARAMS);
        chk(rd, 32'h8);
        set(ATTR_PRESET_VALUE, 32'h0800_0000);
        get(ATTR_WRONG_PARAMS);
        chk(rd, 32'hC);
        set(ATTR_PRESET_VALUE, 32'd50);
        settle();
        chk(pos, 32'd50);
        get(ATTR_OFFSET_VALUE);
        chk(rd, 32'd50);
        raw = 32'd500;
        set(ATTR_COMMAND, 32'h01);
        settle();
        chk(pos, 32'd50);
        get(ATTR_OFFSET_VALUE);
        chk(rd, 32'd450);
        raw = 32'd520;
        repeat (3) settle();
        chk(pos, 32'd70);
        set(ATTR_COMMAND, 32'h01);
        get(ATTR_OFFSET_VALUE);
        chk(rd, 32'd450);
        set(ATTR_COMMAND, 32'h00);
        set(ATTR_COMMAND, 32'h01);
        get(ATTR_OFFSET_VALUE);
        chk(rd, 32'd470);
        set(ATTR_COMMAND, 32'h00);
        set(ATTR_COMMAND, 32'h3E);
        chk({31'h0, busy}, 32'h0);
        get(ATTR_OFFSET_VALUE);
        chk(rd, 32'd470);
        set(ATTR_COMMAND, 32'h40);
        n = 0;
        while (busy === 1'b1 && n < 10) begin
            n++;
            settle();
        end
        chk(n, 32'd4);
        set(ATTR_COMMAND, 32'h00);
        set(ATTR_UNITS_PER_SPAN, 32'h0000_3000);
        set(ATTR_COMMAND, 32'h80);
        get(ATTR_UNITS_PER_SPAN);
        chk(rd, 32'h0000_2000);
        get(ATTR_OFFSET_VALUE);
        chk(rd, 32'h0);
        get(ATTR_PROD_SERIAL);
        chk(rd, 32'h2107_0123);
        get(ATTR_NET_SERIAL);
        chk(rd, 32'hA5C3_0F1E);
        for (int i = 1; i <= 3; i++) begin
            xfer(1'b1, SVC_GET_SINGLE, 8'(i), 32'h0);
            chk(rd, (i == 1) ? 32'h4 : 32'h1);
        end
        xfer(1'b1, SVC_GET_ALL, 8'h00, 32'h0);
        chk(rd, 32'h4);
        for (int i = 0; i < 2; i++) begin
            settle();
            chk({ack, rdata[30:0]}, 32'h8000_0001);
        end
        xfer(1'b1, SVC_SET_SINGLE, CLASS_REVISION, 32'h9);
        chk({31'h0, er}, 32'h1);
        get(8'h7F);
        chk({31'h0, er}, 32'h1);
        finish_test();
    end
endmodule : tb_top
